// ==== gpio_pad_pkg.sv ====
// Purpose: Shared constants for the GPIO pad control block
// Assumes: Registers on a plain port, one aligned 32-bit word each
// Notes: Control byte is {en, dir, pull[1:0], schmitt, slew, drive[1:0]}
package gpio_pad_pkg;
    localparam int NUM_PORTS = 5;
    localparam int NUM_PINS = 16;
    localparam int PORT_W = 4;
    localparam int WIDE_W = 8;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int CFG_W = 6;
    localparam int CTRL_W = 8;
    localparam int IDX_W = 3;

    // Port indices: four narrow 4-bit ports, one wide 8-bit port
    localparam logic [IDX_W-1:0] PORT_WIDE = 3'h4;
    localparam logic [IDX_W-1:0] PORT_LINK = 3'h3;
    localparam int LINK_FIRST_PIN = 12;
    localparam int LINK_OUT_WIRES = 2;
    localparam int WIDE_PINS = 8;
    localparam int P2_FIRST_PIN = 8;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFF_CTRL_BASE = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_DATA_BASE = 8'h20;
    localparam logic [ADDR_W-1:0] OFF_PIN_IN = 8'h40;
    localparam logic [ADDR_W-1:0] OFF_LINK_CTRL = 8'h44;
    localparam logic [ADDR_W-1:0] OFF_LINK_DATA = 8'h48;

    // Control byte fields
    localparam int DRV_LSB = 0;
    localparam int SLEW_BIT = 2;
    localparam int SCHMITT_BIT = 3;
    localparam int PULL_LSB = 4;
    localparam int DIR_BIT = 6;
    localparam int EN_BIT = 7;
    localparam int LINK_EN_BIT = 0;

    // Drive strength codes
    localparam logic [1:0] DRV_2MA = 2'h0;
    localparam logic [1:0] DRV_4MA = 2'h1;
    localparam logic [1:0] DRV_8MA = 2'h2;
    localparam logic [1:0] DRV_12MA = 2'h3;

    // Pull and keep modes
    localparam logic [1:0] PULL_NONE = 2'h0;
    localparam logic [1:0] PULL_DOWN = 2'h1;
    localparam logic [1:0] PULL_UP = 2'h2;
    localparam logic [1:0] PULL_KEEP = 2'h3;

    // Reset: disabled input, 4 mA, fast edges, no Schmitt, no pull
    localparam logic [CTRL_W-1:0] CTRL_RST = 8'h01;
    localparam logic [CFG_W-1:0] CFG_DFLT = 6'h01;
    localparam logic [CTRL_W-1:0] DATA_RST = 8'h00;
    localparam logic [DATA_W-1:0] RDATA_ZERO = 32'h0000_0000;
endpackage

// ==== pad_cfg_decode.sv ====
// Purpose: Turns one port's six control bits into one pad's controls
// Assumes: Caller says whether the pin is owned and driven
// Notes: Pure combinational
`timescale 1ns/1ps
module pad_cfg_decode (
    // Configuration
    input wire logic [gpio_pad_pkg::CFG_W-1:0] cfg,
    input wire logic is_out,
    input wire logic used,
    // Pad controls
    output logic [1:0] drive,
    output logic slew,
    output logic schmitt,
    output logic pull_dn,
    output logic pull_up,
    output logic keep
);
    import gpio_pad_pkg::*;

    wire drv_on = used & is_out;
    wire in_on = used & ~is_out;
    wire [1:0] pull_mode = cfg[PULL_LSB +: 2];

    assign drive = drv_on ? cfg[DRV_LSB +: 2] : DRV_4MA;
    assign slew = drv_on & cfg[SLEW_BIT];
    assign schmitt = in_on & cfg[SCHMITT_BIT];
    // Idle pins are pulled down so they never float
    assign pull_dn = ~used | (in_on & (pull_mode == PULL_DOWN));
    assign pull_up = in_on & (pull_mode == PULL_UP);
    assign keep = in_on & (pull_mode == PULL_KEEP);
endmodule

// ==== gpio_pad_control.sv ====
// Purpose: GPIO port pad configuration and pin ownership
// Assumes: Register master on clk; pad_in is asynchronous
// Notes: Four 4-bit ports, one 8-bit port on pins 0-7, link on 12-15
// Function
// - All pins of one port share direction
// - Output default: 4 mA, fast edges
// - Input default: no Schmitt, no pull
// - Drive selectable: 2, 4, 8, 12 mA
// - Schmitt trigger programmable on inputs
// - Pull-down, pull-up or bus keep selectable
// - Unused pins get weak pull-down
// - Six control bits set per whole port
// - Slew control programmable per port
// - Pin carries bit m of N-bit port
// - Link pins carry link wires by direction
// - Enabled link disables underlying port pins
`timescale 1ns/1ps
module gpio_pad_control (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    // Register port
    input wire logic [gpio_pad_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [gpio_pad_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [gpio_pad_pkg::DATA_W-1:0] reg_rdata,
    // Pad data
    input wire logic [gpio_pad_pkg::NUM_PINS-1:0] pad_in,
    output logic [gpio_pad_pkg::NUM_PINS-1:0] pad_out,
    output logic [gpio_pad_pkg::NUM_PINS-1:0] pad_oe,
    // Pad controls
    output logic [2*gpio_pad_pkg::NUM_PINS-1:0] pad_drive,
    output logic [gpio_pad_pkg::NUM_PINS-1:0] pad_slew,
    output logic [gpio_pad_pkg::NUM_PINS-1:0] pad_schmitt,
    output logic [gpio_pad_pkg::NUM_PINS-1:0] pad_pull_dn,
    output logic [gpio_pad_pkg::NUM_PINS-1:0] pad_pull_up,
    output logic [gpio_pad_pkg::NUM_PINS-1:0] pad_keep
);
    import gpio_pad_pkg::*;

    // State
    logic [CTRL_W-1:0] ctrl_ff [NUM_PORTS];
    logic [CTRL_W-1:0] data_ff [NUM_PORTS];
    logic link_en_ff;
    logic [LINK_OUT_WIRES-1:0] link_tx_ff;
    logic [NUM_PINS-1:0] pin_meta_ff;
    logic [NUM_PINS-1:0] pin_sync_ff;
    logic [DATA_W-1:0] reg_rdata_ff;
    logic [DATA_W-1:0] nxt_rdata;

    // Address decode
    wire [IDX_W-1:0] acc_idx = reg_addr[IDX_W+1:2];
    wire word_ok = (reg_addr[1:0] == 2'h0);
    wire hit_ctrl = word_ok && (reg_addr[7:5] == OFF_CTRL_BASE[7:5])
                    && (acc_idx < IDX_W'(NUM_PORTS));
    wire hit_data = word_ok && (reg_addr[7:5] == OFF_DATA_BASE[7:5])
                    && (acc_idx < IDX_W'(NUM_PORTS));
    wire hit_pin = (reg_addr == OFF_PIN_IN);
    wire hit_lctl = (reg_addr == OFF_LINK_CTRL);
    wire hit_ldat = (reg_addr == OFF_LINK_DATA);
    wire wr_ctrl = ce & reg_wr & hit_ctrl;
    wire wr_data = ce & reg_wr & hit_data;
    wire wr_lctl = ce & reg_wr & hit_lctl;
    wire wr_ldat = ce & reg_wr & hit_ldat;

    // Per-port enable and direction
    wire [NUM_PORTS-1:0] port_en;
    wire [NUM_PORTS-1:0] port_out;
    // Pin values seen by each port, for reads of input ports
    wire [CTRL_W-1:0] port_pins [NUM_PORTS];

    genvar gi;
    generate
        for (gi = 0; gi < NUM_PORTS; gi++) begin : g_port
            assign port_en[gi] = ctrl_ff[gi][EN_BIT];
            // One direction bit per port, so no mixing within it
            assign port_out[gi] = ctrl_ff[gi][DIR_BIT];
            if (gi == PORT_WIDE) begin : g_wide
                assign port_pins[gi] = pin_sync_ff[WIDE_PINS-1:0];
            end else begin : g_narrow
                assign port_pins[gi] = {4'h0,
                    pin_sync_ff[gi*PORT_W +: PORT_W]};
            end
        end
    endgenerate

    // Control registers, written as one unit per port
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < NUM_PORTS; i++) begin
                ctrl_ff[i] <= CTRL_RST;
            end
        end else if (wr_ctrl) begin
            ctrl_ff[acc_idx] <= reg_wdata[CTRL_W-1:0];
        end
    end

    // Output data registers
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < NUM_PORTS; i++) begin
                data_ff[i] <= DATA_RST;
            end
        end else if (wr_data) begin
            data_ff[acc_idx] <= reg_wdata[CTRL_W-1:0];
        end
    end

    // Link control and transmit wires
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            link_en_ff <= 1'b0;
            link_tx_ff <= 2'h0;
        end else begin
            if (wr_lctl) begin
                link_en_ff <= reg_wdata[LINK_EN_BIT];
            end
            if (wr_ldat) begin
                link_tx_ff <= reg_wdata[LINK_OUT_WIRES-1:0];
            end
        end
    end

    // Pad input synchroniser
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pin_meta_ff <= '0;
            pin_sync_ff <= '0;
        end else if (ce) begin
            pin_meta_ff <= pad_in;
            pin_sync_ff <= pin_meta_ff;
        end
    end

    // Read data mux
    wire [DATA_W-1:0] rd_ctrl = {24'h00_0000, ctrl_ff[acc_idx]};
    wire [CTRL_W-1:0] rd_port = port_out[acc_idx] ? data_ff[acc_idx]
                                                  : port_pins[acc_idx];
    wire [DATA_W-1:0] rd_data = {24'h00_0000, rd_port};
    wire [DATA_W-1:0] rd_pin = {16'h0000, pin_sync_ff};
    wire [DATA_W-1:0] rd_lctl = {31'h0000_0000, link_en_ff};
    wire [DATA_W-1:0] rd_ldat = {28'h000_0000,
        pin_sync_ff[NUM_PINS-1 -: 2], link_tx_ff};
    wire [DATA_W-1:0] rd_mux = hit_ctrl ? rd_ctrl :
                               hit_data ? rd_data :
                               hit_pin ? rd_pin :
                               hit_lctl ? rd_lctl :
                               hit_ldat ? rd_ldat : RDATA_ZERO;

    // Read data stands for exactly one ce-enabled cycle after the strobe and holds while ce is low
    assign nxt_rdata = reg_rd ? rd_mux : RDATA_ZERO;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata_ff <= RDATA_ZERO;
        end else if (ce) begin
            reg_rdata_ff <= nxt_rdata;
        end
    end
    assign reg_rdata = reg_rdata_ff;

    // Pin ownership and pad control
    wire [IDX_W-1:0] pin_owner [NUM_PINS];
    wire [2:0] pin_bit [NUM_PINS];
    wire [NUM_PINS-1:0] pin_used;
    wire [NUM_PINS-1:0] pin_link;
    wire [NUM_PINS-1:0] pin_is_out;
    wire [NUM_PINS-1:0] pin_val;

    genvar gp;
    generate
        for (gp = 0; gp < NUM_PINS; gp++) begin : g_pin
            localparam logic [IDX_W-1:0] NARROW = IDX_W'(gp / PORT_W);
            localparam logic [2:0] NBIT = 3'(gp % PORT_W);
            wire [CFG_W-1:0] cfg;
            if (gp < WIDE_PINS) begin : g_shared
                // Narrower port wins over the wide one on shared pins
                assign pin_owner[gp] = port_en[NARROW] ? NARROW
                                                       : PORT_WIDE;
                assign pin_bit[gp] = port_en[NARROW] ? NBIT
                                                     : 3'(gp);
                assign pin_used[gp] = port_en[NARROW] | port_en[PORT_WIDE];
                assign pin_link[gp] = 1'b0;
            end else if (gp < LINK_FIRST_PIN) begin : g_plain
                assign pin_owner[gp] = NARROW;
                assign pin_bit[gp] = NBIT;
                assign pin_used[gp] = port_en[NARROW];
                assign pin_link[gp] = 1'b0;
            end else begin : g_linked
                assign pin_owner[gp] = NARROW;
                assign pin_bit[gp] = NBIT;
                // Link takes the pins away from the port
                assign pin_link[gp] = link_en_ff;
                assign pin_used[gp] = link_en_ff | port_en[NARROW];
            end
            if (gp >= LINK_FIRST_PIN) begin : g_lk
                localparam int WIRE = gp - LINK_FIRST_PIN;
                // Lower link wires are outputs, upper ones inputs
                wire lk_out = (WIRE < LINK_OUT_WIRES);
                wire lk_val = lk_out ? link_tx_ff[WIRE % LINK_OUT_WIRES]
                                     : 1'b0;
                assign pin_is_out[gp] = pin_link[gp] ? lk_out
                                                     : port_out[NARROW];
                assign pin_val[gp] = pin_link[gp] ? lk_val
                    : data_ff[NARROW][NBIT];
                assign cfg = pin_link[gp] ? CFG_DFLT
                                          : ctrl_ff[NARROW][CFG_W-1:0];
            end else begin : g_pt
                assign pin_is_out[gp] = port_out[pin_owner[gp]];
                assign pin_val[gp] = data_ff[pin_owner[gp]][pin_bit[gp]];
                assign cfg = ctrl_ff[pin_owner[gp]][CFG_W-1:0];
            end
            assign pad_oe[gp] = pin_used[gp] & pin_is_out[gp];
            assign pad_out[gp] = pad_oe[gp] & pin_val[gp];
            pad_cfg_decode u_dec (
                .cfg(cfg),
                .is_out(pin_is_out[gp]),
                .used(pin_used[gp]),
                .drive(pad_drive[2*gp +: 2]),
                .slew(pad_slew[gp]),
                .schmitt(pad_schmitt[gp]),
                .pull_dn(pad_pull_dn[gp]),
                .pull_up(pad_pull_up[gp]),
                .keep(pad_keep[gp])
            );
        end
    endgenerate

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    wire p2_out = port_en[2] & port_out[2];
    wire p2_in = port_en[2] & ~port_out[2];
    wire [CFG_W-1:0] p2_cfg = ctrl_ff[2][CFG_W-1:0];

    sequence s_ctrl2_write;
        reg_wr && ce && reg_addr == 8'h08;
    endsequence
    sequence s_ctrl2_read;
        reg_rd && ce && reg_addr == 8'h08 && !(reg_wr);
    endsequence

    a_port_dir_uniform: assert property (
        (pad_oe[11:8] == 4'h0) || (pad_oe[11:8] == 4'hf))
        else $error("port 2 pins mix directions");

    a_out_dflt_drive: assert property (
        (p2_out && p2_cfg == CFG_DFLT) |->
        (pad_drive[17:16] == DRV_4MA) && !pad_slew[8])
        else $error("output default is not 4 mA fast");

    a_in_dflt_pads: assert property (
        (p2_in && p2_cfg == CFG_DFLT) |->
        !pad_schmitt[8] && !pad_pull_dn[8] && !pad_pull_up[8]
        && !pad_keep[8])
        else $error("input default has Schmitt or pull");

    a_drive_write: assert property (
        (s_ctrl2_write ##0 reg_wdata[EN_BIT] && reg_wdata[DIR_BIT])
        |=> (pad_drive[23:22] == $past(reg_wdata[1:0])))
        else $error("drive write not seen on pad");

    a_schmitt_ctl: assert property (
        p2_in |-> (pad_schmitt[9] == ctrl_ff[2][SCHMITT_BIT]))
        else $error("Schmitt does not follow control");

    a_keep_mode: assert property (
        (p2_in && p2_cfg[PULL_LSB +: 2] == PULL_KEEP) |->
        pad_keep[10] && !pad_pull_dn[10] && !pad_pull_up[10])
        else $error("bus keep mode not applied");

    a_unused_pulldn: assert property (
        (!port_en[2]) |-> (pad_pull_dn[11:8] == 4'hf)
        && (pad_oe[11:8] == 4'h0))
        else $error("unused pins not pulled down");

    a_ctrl_readback: assert property (
        (s_ctrl2_write ##1 s_ctrl2_read) |=>
        (reg_rdata[CTRL_W-1:0] == $past(reg_wdata[CTRL_W-1:0], 2)))
        else $error("control readback mismatch");

    a_slew_ctl: assert property (
        p2_out |-> (pad_slew[8] == ctrl_ff[2][SLEW_BIT]))
        else $error("slew does not follow control");

    a_wide_bits: assert property (
        (port_en[PORT_WIDE] && port_out[PORT_WIDE] && !port_en[0]
        && !port_en[1]) |-> (pad_out[7:0] == data_ff[PORT_WIDE]))
        else $error("wide port bit mapping wrong");

    a_link_pins: assert property (
        link_en_ff |-> (pad_oe[15:12] == 4'h3)
        && (pad_out[13:12] == link_tx_ff))
        else $error("link pins not owned by link");

    a_rdata_pulse: assert property (
        !reg_rd && ce |=> (reg_rdata == RDATA_ZERO))
        else $error("read data stands too long");
endmodule

// ==== pad_partner.sv ====
// Purpose: Behavioural model of the circuitry on the pins
// Assumes: Pulled pins without a driver settle at the next clk edge
// Notes: Floating pins without pull or keep toggle every cycle
`timescale 1ns/1ps
module pad_partner (
    // Clock
    input wire logic clk,
    // Pad side of the block
    input wire logic [gpio_pad_pkg::NUM_PINS-1:0] pad_out,
    input wire logic [gpio_pad_pkg::NUM_PINS-1:0] pad_oe,
    input wire logic [gpio_pad_pkg::NUM_PINS-1:0] pad_pull_dn,
    input wire logic [gpio_pad_pkg::NUM_PINS-1:0] pad_pull_up,
    input wire logic [gpio_pad_pkg::NUM_PINS-1:0] pad_keep,
    // External drivers
    input wire logic [gpio_pad_pkg::NUM_PINS-1:0] ext_en,
    input wire logic [gpio_pad_pkg::NUM_PINS-1:0] ext_val,
    output logic [gpio_pad_pkg::NUM_PINS-1:0] pad_in
);
    import gpio_pad_pkg::*;
    initial pad_in = '0;
    always @(posedge clk) begin
        for (int k = 0; k < NUM_PINS; k++) begin
            if (pad_oe[k]) begin
                pad_in[k] <= pad_out[k];
            end else if (ext_en[k]) begin
                pad_in[k] <= ext_val[k];
            end else if (pad_pull_up[k]) begin
                pad_in[k] <= 1'b1;
            end else if (pad_pull_dn[k]) begin
                pad_in[k] <= 1'b0;
            end else if (!pad_keep[k]) begin
                pad_in[k] <= ~pad_in[k];
            end
        end
    end
endmodule

// ==== test_gpio_pad_control.sv ====
// Purpose: Self-checking bench for the GPIO pad control block
// Assumes: Register port strobes one cycle, read data one cycle later
// Notes: Narrow ports shadowed; wide port and link checked by hand
`timescale 1ns/1ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin \
    fail_count++; $display("unexpected %s exp %h got %h", nm, e, g); end end
module test_gpio_pad_control;
    import gpio_pad_pkg::*;
    logic clk = 0, rst_b = 0, ce = 1, reg_wr = 0, reg_rd = 0;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic [DATA_W-1:0] reg_wdata = '0, reg_rdata, rd_val;
    logic [NUM_PINS-1:0] pad_in, pad_out, pad_oe, pad_slew, pad_schmitt;
    logic [NUM_PINS-1:0] pad_pull_dn, pad_pull_up, pad_keep;
    logic [2*NUM_PINS-1:0] pad_drive;
    logic [NUM_PINS-1:0] ext_en = '1, ext_val = '0;
    logic [31:0] rnd = 32'h617f_23a1;
    logic [7:0] ctrl_sh [0:3];
    logic [3:0] dat_sh [0:3];
    logic [7:0] c;
    logic [3:0] d;
    int fail_count = 0, check_count = 0, cyc = 0, p;
    always #12.5 clk = ~clk;
    gpio_pad_control uut (.clk(clk), .rst_b(rst_b), .ce(ce),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pad_in(pad_in),
        .pad_out(pad_out), .pad_oe(pad_oe), .pad_drive(pad_drive),
        .pad_slew(pad_slew), .pad_schmitt(pad_schmitt),
        .pad_pull_dn(pad_pull_dn), .pad_pull_up(pad_pull_up),
        .pad_keep(pad_keep));
    pad_partner partner (.clk(clk), .pad_out(pad_out), .pad_oe(pad_oe),
        .pad_pull_dn(pad_pull_dn), .pad_pull_up(pad_pull_up),
        .pad_keep(pad_keep), .ext_en(ext_en), .ext_val(ext_val),
        .pad_in(pad_in));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // Packed {oe, drive, slew, schmitt, pull_dn, pull_up, keep}
    function automatic logic [7:0] exp_pin(input logic [7:0] cb);
        logic o;
        logic i;
        o = cb[EN_BIT] & cb[DIR_BIT];
        i = cb[EN_BIT] & !cb[DIR_BIT];
        return {o, o ? cb[1:0] : DRV_4MA, o & cb[SLEW_BIT],
            i & cb[SCHMITT_BIT], !cb[EN_BIT] | (i & cb[5:4] == PULL_DOWN),
            i & cb[5:4] == PULL_UP, i & cb[5:4] == PULL_KEEP};
    endfunction
    task automatic conclude;
        if (fail_count == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clk);
        reg_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        rd_val = reg_rdata;
    endtask
    // Write then read with no idle cycle between the strobes
    task automatic wr_rd(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        rd_val = reg_rdata;
    endtask
    task automatic chk_pin(input int k, input logic [7:0] cb);
        logic [7:0] got;
        got = {pad_oe[k], pad_drive[2*k+:2], pad_slew[k], pad_schmitt[k],
            pad_pull_dn[k], pad_pull_up[k], pad_keep[k]};
        `CHK("pad", exp_pin(cb), got)
    endtask
    task automatic chk_all;
        logic [NUM_PINS-1:0] eo;
        for (int k = 0; k < NUM_PINS; k++) begin
            chk_pin(k, ctrl_sh[k/4]);
            eo[k] = ctrl_sh[k/4][EN_BIT] & ctrl_sh[k/4][DIR_BIT]
                & dat_sh[k/4][k%4];
        end
        `CHK("pad_out", eo, pad_out)
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 6000) begin
            fail_count++;
            conclude();
        end
    end
    initial begin
        for (int i = 0; i < 4; i++) begin
            ctrl_sh[i] = CTRL_RST;
            dat_sh[i] = 4'h0;
        end
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        step(1);
        chk_all();
        for (int i = 0; i < 5; i++) begin
            rd(OFF_CTRL_BASE + 8'(4*i));
            `CHK("ctrl_rst", 32'(CTRL_RST), rd_val)
        end
        for (int it = 0; it < 24; it++) begin
            p = it % 4;
            rnd = lfsr(lfsr(rnd));
            c = rnd[7:0];
            if (it < 8) begin
                c = {1'b1, it[2], it[1:0], rnd[3], rnd[2], it[1:0]};
            end
            d = rnd[11:8];
            wr(OFF_CTRL_BASE + 8'(4*p), 32'(c));
            wr(OFF_DATA_BASE + 8'(4*p), 32'(d));
            ctrl_sh[p] = c;
            dat_sh[p] = d;
            ext_val <= rnd[31:16];
            step(4);
            chk_all();
            rd(OFF_CTRL_BASE + 8'(4*p));
            `CHK("ctrl_rd", 32'(c), rd_val)
            rd(OFF_DATA_BASE + 8'(4*p));
            if (!c[DIR_BIT]) begin
                d = ext_val[4*p+:4];
            end
            `CHK("data_rd", d, rd_val[3:0])
        end
        // Port 2 input default, output default, bus keep
        for (int i = 0; i < 3; i++) begin
            c = (i == 0) ? 8'h81 : (i == 1) ? 8'hc1 : 8'hb8;
            wr_rd(OFF_CTRL_BASE + 8'h08, 32'(c));
            `CHK("ctrl_b2b", 32'(c), rd_val)
            ctrl_sh[2] = c;
            chk_all();
        end
        ext_en <= '0;
        for (int i = 0; i < 2; i++) begin
            c = i ? {2'b10, PULL_DOWN, 4'h1} : {2'b10, PULL_UP, 4'h1};
            wr(OFF_CTRL_BASE + 8'h08, 32'(c));
            ctrl_sh[2] = c;
            step(5);
            rd(OFF_DATA_BASE + 8'h08);
            `CHK("pull_lvl", i ? 4'h0 : 4'hF, rd_val[3:0])
        end
        ext_en <= '1;
        for (int i = 0; i < 2; i++) begin
            wr(OFF_CTRL_BASE + 8'(4*i), 32'(CTRL_RST));
            ctrl_sh[i] = CTRL_RST;
        end
        wr(OFF_CTRL_BASE + 8'h10, 32'h0000_00c3);
        wr(OFF_DATA_BASE + 8'h10, 32'h0000_00a5);
        for (int k = 0; k < WIDE_PINS; k++) chk_pin(k, 8'hc3);
        `CHK("wide_out", 8'ha5, pad_out[7:0])
        wr(OFF_CTRL_BASE, 32'h0000_0080);
        for (int k = 0; k < WIDE_PINS; k++) chk_pin(k, k < 4 ? 8'h80 : 8'hc3);
        `CHK("wide_shr", 8'ha0, pad_out[7:0])
        wr(OFF_CTRL_BASE + 8'h10, 32'(CTRL_RST));
        wr(OFF_CTRL_BASE, 32'(CTRL_RST));
        wr(OFF_CTRL_BASE + 8'h0c, 32'h0000_00c0);
        wr(OFF_DATA_BASE + 8'h0c, 32'h0000_000f);
        ctrl_sh[3] = 8'hc0;
        dat_sh[3] = 4'hf;
        wr(OFF_LINK_CTRL, 32'h0000_0001);
        wr(OFF_LINK_DATA, 32'h0000_0002);
        ext_val[15:14] <= 2'b01;
        for (int k = 12; k < 16; k++) chk_pin(k, k < 14 ? 8'hc1 : 8'h81);
        `CHK("link_out", 4'h2, pad_out[15:12])
        step(4);
        rd(OFF_LINK_DATA);
        `CHK("link_in", 2'b01, rd_val[3:2])
        wr(OFF_LINK_CTRL, 32'h0000_0000);
        chk_all();
        wr(8'h4c, 32'hffff_ffff);
        rd(8'h4c);
        `CHK("unmapped", RDATA_ZERO, rd_val)
        rd(8'h09);
        `CHK("unaligned", RDATA_ZERO, rd_val)
        @(posedge clk);
        ce <= 1'b0;
        wr(OFF_CTRL_BASE + 8'h08, 32'h0000_00c3);
        @(posedge clk);
        ce <= 1'b1;
        #1;
        chk_all();
        @(posedge clk);
        rst_b <= 1'b0;
        step(2);
        for (int i = 0; i < 4; i++) begin
            ctrl_sh[i] = CTRL_RST;
            dat_sh[i] = 4'h0;
        end
        chk_all();
        @(posedge clk);
        rst_b <= 1'b1;
        step(1);
        chk_all();
        conclude();
    end
endmodule
